// file: hw/daim_monitor.sv
// Digital audio input monitor: error log, mute, clock fallback, level and status bits
// Notes on behaviour
// - Count a validity error for every frame with its validity bit set.
// - Count a line-quality error when the receiver flags jitter or noise.
// - Count a misaligned-sample error when a sample slips out of the word window.
// - Count a checksum error when the stream CRC does not match.
// - Count parity and biphase coding errors in separate counters.
// - Each type has its own count, shown up to 9999, overflow shown above.
// - Remember which error type arrived most recently.
// - Counting goes on whenever external clock is selected, whether or not anyone reads it.
// - Reselecting external clock restarts lock search and zeroes all counts.
// - The log is also zeroed at reset and on every automatic relock.
// - Mute digital input on lock loss, rate fault or non-audio data.
// - Latch a fault notice until a front-panel button press clears it.
// - While muted, still report the chosen level plus a muted flag.
// - Scale left and right digital input by a 0 to 100 percent gain.
// - Digital gain path is off whenever an internal word clock is chosen.
// - On lock loss go at once to internal clock at last detected rate.
// - Auto relock retries continuously; otherwise stay internal until reselect.
// - Outgoing copy control: no copy, one copy or unlimited copies.
// - Outgoing emphasis flag forced on, forced off, or passed through.
// - Flag a rate fault when the frame rate leaves the 4 percent tolerance.
// - Clock source is external, internal 48 kHz or internal 44.1 kHz.
`include "daim_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module daim_monitor
    import daim_pkg::*;
#(
    parameter int COUNT_W = 14,
    parameter int PERIOD_W = 10
)
(
    // System clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Link side, on the recovered receive clock
    input wire logic i_link_clock,
    input wire logic i_link_frame,
    input wire daim_frame_t i_link_frame_info,
    input wire logic i_link_locked,
    // Front panel settings
    input wire daim_clock_sel_t i_clock_sel,
    input wire logic i_ext_reselect,
    input wire logic i_auto_relock,
    input wire logic [6:0] i_dig_level,
    input wire daim_copy_t i_copy_mode,
    input wire daim_emph_t i_emph_mode,
    input wire logic i_button,
    // Clock control
    output logic o_use_internal,
    output logic o_internal_48k,
    output logic o_relock,
    // Error log
    output logic [`DAIM_ERR_TYPES-1:0][COUNT_W-1:0] o_err_count,
    output logic [`DAIM_ERR_TYPES-1:0] o_err_over,
    output logic [2:0] o_last_error,
    output logic o_last_valid,
    // Fault status
    output logic o_muted,
    output logic o_rate_fault,
    output logic o_detected_48k,
    output daim_notice_t o_notice,
    output logic [6:0] o_level_shown,
    // Audio path
    output logic o_sample_valid,
    output logic [23:0] o_left,
    output logic [23:0] o_right,
    output daim_status_bits_t o_status_bits
);

    localparam logic [COUNT_W-1:0] COUNT_TOP = {COUNT_W{1'b1}};
    localparam logic [COUNT_W-1:0] COUNT_SHOWN = COUNT_W'(`DAIM_COUNT_SHOWN_MAX);
    localparam logic [PERIOD_W-1:0] PERIOD_TOP = {PERIOD_W{1'b1}};
    localparam logic [PERIOD_W-1:0] PERIOD_MIN = PERIOD_W'(`DAIM_PERIOD_MIN);
    localparam logic [PERIOD_W-1:0] PERIOD_MAX = PERIOD_W'(`DAIM_PERIOD_MAX);
    localparam logic [PERIOD_W-1:0] PERIOD_MID = PERIOD_W'(`DAIM_PERIOD_MID);
    localparam logic [6:0] GAIN_FULL = 7'(`DAIM_GAIN_FULL);

    // Link domain: frame capture and event toggle
    daim_frame_t link_frame;
    logic link_toggle;

    always_ff @(posedge i_link_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            link_frame <= '0;
            link_toggle <= 1'b0;
        end
        else if (i_link_frame)
        begin
            link_frame <= i_link_frame_info;
            link_toggle <= ~link_toggle;
        end
    end

    // System domain: synchronisers
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic lock_s1;
    logic lock_s2;
    logic btn_s1;
    logic btn_s2;
    logic btn_s3;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
            lock_s1 <= 1'b0;
            lock_s2 <= 1'b0;
            btn_s1 <= 1'b0;
            btn_s2 <= 1'b0;
            btn_s3 <= 1'b0;
        end
        else
        begin
            tog_s1 <= link_toggle;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
            lock_s1 <= i_link_locked;
            lock_s2 <= lock_s1;
            btn_s1 <= i_button;
            btn_s2 <= btn_s1;
            btn_s3 <= btn_s2;
        end
    end

    logic frame_evt;
    logic button_press;
    assign frame_evt = tog_s2 ^ tog_s3;
    assign button_press = btn_s2 & ~btn_s3;

    // Frame word is held stable for a whole frame, so it is taken on the event
    daim_frame_t frame;
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            frame <= '0;
        end
        else if (frame_evt)
        begin
            frame <= link_frame;
        end
    end

    logic frame_seen;
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            frame_seen <= 1'b0;
        end
        else
        begin
            frame_seen <= frame_evt;
        end
    end

    // Reselection of the external source
    daim_clock_sel_t sel_q;
    logic reselect;
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            sel_q <= DAIM_SEL_INT48;
        end
        else
        begin
            sel_q <= i_clock_sel;
        end
    end
    assign reselect = (i_clock_sel == DAIM_SEL_EXT) &&
        ((sel_q != DAIM_SEL_EXT) || i_ext_reselect);

    // Frame period measurement for rate check
    logic [PERIOD_W-1:0] period;
    logic period_ok;
    logic rate_fault;
    logic det_48k;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            period <= '0;
            period_ok <= 1'b0;
        end
        else if (reselect || !lock_s2)
        begin
            period <= '0;
            period_ok <= 1'b0;
        end
        else if (frame_evt)
        begin
            period <= '0;
            period_ok <= 1'b1;
        end
        else if (period != PERIOD_TOP)
        begin
            period <= period + 1'b1;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            rate_fault <= 1'b0;
            det_48k <= 1'b1;
        end
        else if (reselect || !lock_s2)
        begin
            rate_fault <= 1'b0;
        end
        else if (frame_evt && period_ok)
        begin
            if (period < PERIOD_MIN || period > PERIOD_MAX)
            begin
                rate_fault <= 1'b1;
            end
            else
            begin
                rate_fault <= 1'b0;
                det_48k <= (period <= PERIOD_MID);
            end
        end
    end

    // Clock source state machine
    daim_state_t state;
    daim_state_t next_state;
    logic relock;

    always_comb
    begin
        next_state = state;
        relock = 1'b0;
        case (state)
            DAIM_ST_INTERNAL:
            begin
                if (reselect)
                begin
                    next_state = DAIM_ST_ACQUIRE;
                end
            end
            DAIM_ST_ACQUIRE:
            begin
                if (lock_s2)
                begin
                    next_state = DAIM_ST_LOCKED;
                end
            end
            DAIM_ST_LOCKED:
            begin
                if (!lock_s2)
                begin
                    next_state = DAIM_ST_FALLBACK;
                end
            end
            DAIM_ST_FALLBACK:
            begin
                if (i_auto_relock && lock_s2)
                begin
                    next_state = DAIM_ST_LOCKED;
                    relock = 1'b1;
                end
            end
            default:
            begin
                next_state = DAIM_ST_INTERNAL;
            end
        endcase
        if (i_clock_sel != DAIM_SEL_EXT)
        begin
            next_state = DAIM_ST_INTERNAL;
            relock = 1'b0;
        end
        else if (reselect)
        begin
            next_state = DAIM_ST_ACQUIRE;
            relock = 1'b0;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            state <= DAIM_ST_INTERNAL;
            o_relock <= 1'b0;
        end
        else
        begin
            state <= next_state;
            o_relock <= relock;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_use_internal <= 1'b1;
            o_internal_48k <= 1'b1;
        end
        else
        begin
            o_use_internal <= (next_state != DAIM_ST_LOCKED);
            if (i_clock_sel == DAIM_SEL_INT48)
            begin
                o_internal_48k <= 1'b1;
            end
            else if (i_clock_sel == DAIM_SEL_INT441)
            begin
                o_internal_48k <= 1'b0;
            end
            else if (next_state == DAIM_ST_FALLBACK && state == DAIM_ST_LOCKED)
            begin
                o_internal_48k <= det_48k;
            end
        end
    end

    // Error log clear and counting
    logic log_clear;
    logic ext_sel;
    assign log_clear = reselect | relock;
    assign ext_sel = (i_clock_sel == DAIM_SEL_EXT);

    logic [`DAIM_ERR_TYPES-1:0] err_hit;
    assign err_hit = (frame_seen && ext_sel) ? frame.errors : '0;

    genvar gi;
    generate
        for (gi = 0; gi < `DAIM_ERR_TYPES; gi++)
        begin : g_count
            logic [COUNT_W-1:0] count;
            logic [COUNT_W-1:0] next_count;
            assign next_count = (count == COUNT_TOP) ? count : count + 1'b1;
            always_ff @(posedge i_clock or posedge i_rst)
            begin
                if (i_rst)
                begin
                    count <= '0;
                    o_err_count[gi] <= '0;
                    o_err_over[gi] <= 1'b0;
                end
                else if (log_clear)
                begin
                    count <= '0;
                    o_err_count[gi] <= '0;
                    o_err_over[gi] <= 1'b0;
                end
                else if (err_hit[gi])
                begin
                    count <= next_count;
                    o_err_count[gi] <= (next_count > COUNT_SHOWN) ?
                        COUNT_SHOWN : next_count;
                    o_err_over[gi] <= (next_count > COUNT_SHOWN);
                end
            end
        end
    endgenerate

    // Most recent error type, lowest index wins within one frame
    logic [2:0] next_last;
    always_comb
    begin
        next_last = 3'h0;
        for (int k = `DAIM_ERR_TYPES - 1; k >= 0; k--)
        begin
            if (err_hit[k])
            begin
                next_last = 3'(k);
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_last_error <= 3'h0;
            o_last_valid <= 1'b0;
        end
        else if (log_clear)
        begin
            o_last_error <= 3'h0;
            o_last_valid <= 1'b0;
        end
        else if (|err_hit)
        begin
            o_last_error <= next_last;
            o_last_valid <= 1'b1;
        end
    end

    // Mute decision and fault notice
    logic locked_run;
    logic muted;
    assign locked_run = (state == DAIM_ST_LOCKED);
    assign muted = !locked_run || rate_fault || frame.non_audio;

    daim_notice_t notice_set;
    assign notice_set.lock = ext_sel && (state == DAIM_ST_LOCKED) && !lock_s2;
    assign notice_set.rate = frame_evt && period_ok && rate_fault == 1'b0 &&
        (period < PERIOD_MIN || period > PERIOD_MAX);
    assign notice_set.non_audio = frame_seen && ext_sel && frame.non_audio && !o_notice.non_audio;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_notice <= '0;
        end
        else
        begin
            o_notice <= (button_press ? '0 : o_notice) | notice_set;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_muted <= 1'b1;
            o_rate_fault <= 1'b0;
            o_detected_48k <= 1'b1;
            o_level_shown <= 7'h00;
        end
        else
        begin
            o_muted <= muted;
            o_rate_fault <= rate_fault;
            o_detected_48k <= det_48k;
            o_level_shown <= (i_dig_level > GAIN_FULL) ? GAIN_FULL : i_dig_level;
        end
    end

    // Gain scaling of the digital input
    logic [6:0] gain;
    logic [16:0] scale;
    logic signed [41:0] prod_l;
    logic signed [41:0] prod_r;
    assign gain = (i_dig_level > GAIN_FULL) ? GAIN_FULL : i_dig_level;
    assign scale = 17'((32'(gain) * 32'(`DAIM_GAIN_UNITY) + 32'd50) / 32'(`DAIM_GAIN_FULL));
    assign prod_l = 42'($signed(frame.left) * $signed({1'b0, scale}));
    assign prod_r = 42'($signed(frame.right) * $signed({1'b0, scale}));

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_sample_valid <= 1'b0;
            o_left <= 24'h00_0000;
            o_right <= 24'h00_0000;
        end
        else if (frame_seen)
        begin
            o_sample_valid <= 1'b1;
            if (!ext_sel || muted)
            begin
                o_left <= 24'h00_0000;
                o_right <= 24'h00_0000;
            end
            else
            begin
                o_left <= prod_l[39:16];
                o_right <= prod_r[39:16];
            end
        end
        else
        begin
            o_sample_valid <= 1'b0;
        end
    end

    // Outgoing channel status bits
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_status_bits <= '0;
        end
        else
        begin
            case (i_copy_mode)
                DAIM_COPY_NONE:
                begin
                    o_status_bits.copy_permit <= 1'b0;
                    o_status_bits.generation <= 1'b1;
                end
                DAIM_COPY_ONE:
                begin
                    o_status_bits.copy_permit <= 1'b0;
                    o_status_bits.generation <= 1'b0;
                end
                default:
                begin
                    o_status_bits.copy_permit <= 1'b1;
                    o_status_bits.generation <= 1'b0;
                end
            endcase
            case (i_emph_mode)
                DAIM_EMPH_ON:
                begin
                    o_status_bits.emphasis <= 1'b1;
                end
                DAIM_EMPH_OFF:
                begin
                    o_status_bits.emphasis <= 1'b0;
                end
                default:
                begin
                    o_status_bits.emphasis <= frame.emphasis;
                end
            endcase
        end
    end

endmodule // daim_monitor
`default_nettype wire

// file: hw/daim_pkg.sv
// Types for the digital audio input monitor
package daim_pkg;
    typedef enum logic [1:0] {
        DAIM_SEL_EXT = 2'b00,
        DAIM_SEL_INT48 = 2'b01,
        DAIM_SEL_INT441 = 2'b10
    } daim_clock_sel_t;
    typedef enum logic [1:0] {
        DAIM_ST_INTERNAL = 2'b00,
        DAIM_ST_ACQUIRE = 2'b01,
        DAIM_ST_LOCKED = 2'b10,
        DAIM_ST_FALLBACK = 2'b11
    } daim_state_t;
    typedef enum logic [1:0] {
        DAIM_COPY_NONE = 2'b00,
        DAIM_COPY_ONE = 2'b01,
        DAIM_COPY_MULTI = 2'b10
    } daim_copy_t;
    typedef enum logic [1:0] {
        DAIM_EMPH_ON = 2'b00,
        DAIM_EMPH_OFF = 2'b01,
        DAIM_EMPH_PASS = 2'b10
    } daim_emph_t;
    typedef struct packed {
        logic [5:0] errors;
        logic non_audio;
        logic emphasis;
        logic [23:0] left;
        logic [23:0] right;
    } daim_frame_t;
    typedef struct packed {
        logic copy_permit;
        logic generation;
        logic emphasis;
    } daim_status_bits_t;
    typedef struct packed {
        logic lock;
        logic rate;
        logic non_audio;
    } daim_notice_t;
endpackage

// file: hw/daim_regs.svh
// Constants for the digital audio input monitor
`ifndef DAIM_REGS_SVH
`define DAIM_REGS_SVH
`define DAIM_CLK_HZ 10000000
`define DAIM_RATE_HI_HZ 48000
`define DAIM_RATE_LO_HZ 44100
`define DAIM_RATE_TOL_PCT 4
`define DAIM_PERIOD_MIN ((`DAIM_CLK_HZ * 100) / (`DAIM_RATE_HI_HZ * (100 + `DAIM_RATE_TOL_PCT)))
`define DAIM_PERIOD_MAX ((`DAIM_CLK_HZ * 100) / (`DAIM_RATE_LO_HZ * (100 - `DAIM_RATE_TOL_PCT)))
`define DAIM_PERIOD_MID ((`DAIM_PERIOD_MIN + `DAIM_PERIOD_MAX) / 2)
`define DAIM_COUNT_SHOWN_MAX 9999
`define DAIM_GAIN_FULL 100
`define DAIM_GAIN_UNITY 65536
`define DAIM_ERR_TYPES 6
`define DAIM_ERR_VALIDITY 0
`define DAIM_ERR_LINE_QUALITY 1
`define DAIM_ERR_MISALIGNED 2
`define DAIM_ERR_CHECKSUM 3
`define DAIM_ERR_PARITY 4
`define DAIM_ERR_BIPHASE 5
`endif

// file: sim/daim_link_tx.sv
// Behavioural model of the far-side digital audio transmitter
`timescale 1ns/1ns
`default_nettype none
module daim_link_tx
    import daim_pkg::*;
(
    // Frame request from the bench
    input wire logic i_send,
    input wire daim_frame_t i_info,
    // Link toward the monitor
    output logic o_link_clock,
    output logic o_link_frame,
    output daim_frame_t o_link_info
);
    initial
    begin
        o_link_clock = 1'b0;
        o_link_frame = 1'b0;
        o_link_info = '0;
    end
    // Clock runs only for the two cycles of a frame; data inverted once released
    always @(posedge i_send)
    begin
        o_link_info = i_info;
        o_link_frame = 1'b1;
        #(30 + i_info.left[4:0]) o_link_clock = 1'b1;
        #63 o_link_clock = 1'b0;
        o_link_frame = 1'b0;
        o_link_info = ~i_info;
        #62 o_link_clock = 1'b1;
        #63 o_link_clock = 1'b0;
    end
endmodule // daim_link_tx
`default_nettype wire

// file: sim/daim_monitor_properties.sv
// Port-level assertions for the digital audio input monitor
`timescale 1ns/1ns
`default_nettype none
module daim_monitor_properties
    import daim_pkg::*;
#(
    parameter int COUNT_W = 14
)
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Watched inputs
    input wire logic i_link_locked,
    input wire daim_clock_sel_t i_clock_sel,
    input wire logic i_ext_reselect,
    input wire daim_copy_t i_copy_mode,
    input wire logic i_button,
    // Watched outputs
    input wire logic o_use_internal,
    input wire logic o_relock,
    input wire logic [5:0][COUNT_W-1:0] o_err_count,
    input wire logic [5:0] o_err_over,
    input wire logic o_last_valid,
    input wire logic o_muted,
    input wire logic o_rate_fault,
    input wire daim_notice_t o_notice,
    input wire daim_status_bits_t o_status_bits
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);
    count_clamp_a:
        assert property (o_err_over[0] |-> o_err_count[0] == 14'h270f)
        else $error("overflow without clamped count");
    notice_hold_a:
        assert property (($past(o_notice) & ~o_notice) != 3'h0
            |-> $past(i_button, 2) || $past(i_button, 3) || $past(i_button, 4))
        else $error("notice dropped without button");
    lock_fallback_a:
        assert property ($fell(i_link_locked) && !o_use_internal |-> ##[1:6] o_use_internal)
        else $error("no fallback after lock loss");
    reselect_clear_a:
        assert property (i_ext_reselect && i_clock_sel == DAIM_SEL_EXT
            |-> ##[1:2] (o_err_count == '0 && !o_last_valid))
        else $error("log not cleared on reselect");
    relock_clear_a:
        assert property (o_relock |-> ##[0:1] o_err_count == '0)
        else $error("log not cleared on relock");
    internal_freeze_a:
        assert property ((i_clock_sel != DAIM_SEL_EXT) [*2] |=> $stable(o_err_count))
        else $error("count moved on internal clock");
    rate_mute_a:
        assert property ($rose(o_rate_fault) |-> ##[0:1] (o_muted && o_notice.rate))
        else $error("rate fault without mute and notice");
    copy_bits_a:
        assert property (!$past(i_rst) |-> o_status_bits.copy_permit ==
            ($past(i_copy_mode) == DAIM_COPY_MULTI) && o_status_bits.generation ==
            ($past(i_copy_mode) == DAIM_COPY_NONE))
        else $error("copy bits do not follow mode");
    relock_seen_c: cover property (o_relock);
    rate_fault_seen_c: cover property ($rose(o_rate_fault));
    overflow_seen_c: cover property (o_err_over[0]);
endmodule // daim_monitor_properties
bind daim_monitor daim_monitor_properties #(.COUNT_W(COUNT_W)) daim_monitor_properties_i (
    .i_clock, .i_rst, .i_link_locked, .i_clock_sel, .i_ext_reselect, .i_copy_mode, .i_button,
    .o_use_internal, .o_relock, .o_err_count, .o_err_over, .o_last_valid, .o_muted,
    .o_rate_fault, .o_notice, .o_status_bits
);
`default_nettype wire

// file: sim/tb_daim_monitor.sv
// Self-checking bench for the digital audio input monitor
`timescale 1ns/1ns
`default_nettype none
module tb_daim_monitor
    import daim_pkg::*;
;
    logic i_clock, i_rst, i_link_locked, i_ext_reselect, i_auto_relock, i_button;
    logic send, link_clock, link_frame, o_use_internal, o_internal_48k, o_relock;
    logic o_last_valid, o_muted, o_rate_fault, o_detected_48k, o_sample_valid;
    logic [5:0][13:0] o_err_count;
    logic [5:0] o_err_over;
    logic [2:0] o_last_error;
    logic [6:0] i_dig_level, o_level_shown;
    logic [23:0] o_left, o_right;
    logic [15:0] lfsr;
    daim_frame_t info, link_info, f;
    daim_clock_sel_t i_clock_sel;
    daim_copy_t i_copy_mode;
    daim_emph_t i_emph_mode;
    daim_notice_t o_notice;
    daim_status_bits_t o_status_bits;
    int error_cnt, compares, last;
    int cnt[6];
    daim_monitor daim_monitor_i (
        .i_clock, .i_rst, .i_link_clock(link_clock), .i_link_frame(link_frame),
        .i_link_frame_info(link_info), .i_link_locked, .i_clock_sel, .i_ext_reselect,
        .i_auto_relock, .i_dig_level, .i_copy_mode, .i_emph_mode, .i_button,
        .o_use_internal, .o_internal_48k, .o_relock, .o_err_count, .o_err_over,
        .o_last_error, .o_last_valid, .o_muted, .o_rate_fault, .o_detected_48k,
        .o_notice, .o_level_shown, .o_sample_valid, .o_left, .o_right, .o_status_bits
    );
    daim_link_tx daim_link_tx_i (
        .i_send(send), .i_info(info), .o_link_clock(link_clock),
        .o_link_frame(link_frame), .o_link_info(link_info)
    );
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction
    function automatic logic [23:0] scale(input logic [23:0] s, input int lv);
        logic [63:0] p;
        p = longint'($signed(s)) * longint'((lv * 65536 + 50) / 100);
        return p[39:16];
    endfunction
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
        #10;
    endtask
    task automatic wait_hi(input int w);
        int k;
        k = 0;
        while ((w ? o_relock : o_sample_valid) !== 1'b1 && k < 20)
        begin
            cyc(1);
            k++;
        end
        chk(w ? o_relock : o_sample_valid, 1);
    endtask
    task automatic frame(input daim_frame_t fr, input int gap, input int m);
        int lv;
        lv = i_dig_level > 7'h64 ? 100 : int'(i_dig_level);
        info = fr;
        send = 1'b1;
        cyc(1);
        send = 1'b0;
        wait_hi(0);
        if (i_clock_sel == DAIM_SEL_EXT)
            for (int t = 5; t >= 0; t--)
                if (fr.errors[t])
                begin
                    cnt[t] += cnt[t] < 10000;
                    last = t;
                end
        for (int t = 0; t < 6; t++)
        begin
            chk(o_err_count[t], cnt[t] > 9999 ? 9999 : cnt[t]);
            chk(o_err_over[t], cnt[t] > 9999);
        end
        chk(o_last_valid, last >= 0);
        if (last >= 0)
            chk(o_last_error, last);
        chk(o_level_shown, lv);
        chk(o_status_bits[2:1],
            {i_copy_mode == DAIM_COPY_MULTI, i_copy_mode == DAIM_COPY_NONE});
        chk(o_status_bits.emphasis,
            i_emph_mode == DAIM_EMPH_PASS ? fr.emphasis : i_emph_mode == DAIM_EMPH_ON);
        if (m < 2)
            chk({o_left, o_right}, m ? 48'h0 : {scale(fr.left, lv), scale(fr.right, lv)});
        cyc(gap - 6);
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end
    initial
    begin
        repeat (90000) @(posedge i_clock);
        error_cnt++;
        complete_run();
    end
    initial
    begin
        lfsr = 16'h0034;
        error_cnt = 0;
        compares = 0;
        last = -1;
        cnt = '{default: 0};
        i_rst = 1'b1;
        send = 1'b0;
        info = '0;
        f = '0;
        i_link_locked = 1'b1;
        i_ext_reselect = 1'b0;
        i_auto_relock = 1'b1;
        i_button = 1'b0;
        i_clock_sel = DAIM_SEL_INT48;
        i_dig_level = 7'h64;
        i_copy_mode = DAIM_COPY_NONE;
        i_emph_mode = DAIM_EMPH_PASS;
        cyc(5);
        chk({o_use_internal, o_muted, o_err_count}, {2'b11, 84'h0});
        i_rst = 1'b0;
        i_clock_sel = DAIM_SEL_EXT;
        cyc(10);
        chk(o_use_internal, 0);
        $display("done: reset and lock");
        repeat (2) frame(f, 210, 2);
        for (int n = 0; n < 40; n++)
        begin
            i_dig_level = n == 0 ? 7'h7f : n == 1 ? 7'h00 : 7'(rnd() % 101);
            i_copy_mode = daim_copy_t'(rnd() % 3);
            i_emph_mode = daim_emph_t'(rnd() % 3);
            f = {6'(rnd()), 1'b0, 1'(rnd()), rnd(), rnd(), rnd()};
            frame(f, 210, 0);
            chk({o_rate_fault, o_detected_48k}, 2'b01);
        end
        $display("done: random frames");
        cyc(50);
        frame(f, 230, 2);
        chk({o_rate_fault, o_notice.rate, o_muted}, 3'b111);
        repeat (2) frame(f, 230, 2);
        frame(f, 230, 0);
        chk({o_rate_fault, o_detected_48k, o_notice.rate}, 3'b001);
        i_button = 1'b1;
        cyc(6);
        i_button = 1'b0;
        chk(o_notice, 0);
        f.non_audio = 1'b1;
        frame(f, 230, 2);
        chk({o_muted, o_notice.non_audio}, 2'b11);
        f.non_audio = 1'b0;
        repeat (2) frame(f, 230, 2);
        chk({o_muted, o_notice.non_audio}, 2'b01);
        $display("done: faults");
        f.errors = 6'h3f;
        frame(f, 230, 2);
        i_link_locked = 1'b0;
        cyc(6);
        chk({o_use_internal, o_internal_48k, o_notice.lock, o_muted}, 4'b1011);
        i_link_locked = 1'b1;
        wait_hi(1);
        cyc(1);
        cnt = '{default: 0};
        last = -1;
        chk({o_err_count, o_last_valid}, 0);
        frame(f, 230, 2);
        i_auto_relock = 1'b0;
        i_link_locked = 1'b0;
        cyc(6);
        i_link_locked = 1'b1;
        cyc(20);
        chk(o_use_internal, 1);
        i_ext_reselect = 1'b1;
        cyc(1);
        i_ext_reselect = 1'b0;
        cyc(2);
        chk({o_err_count, o_last_valid}, 0);
        cnt = '{default: 0};
        last = -1;
        cyc(8);
        chk(o_use_internal, 0);
        $display("done: lock loss");
        i_clock_sel = DAIM_SEL_INT48;
        cyc(3);
        chk({o_use_internal, o_internal_48k}, 2'b11);
        frame(f, 230, 1);
        i_clock_sel = DAIM_SEL_INT441;
        cyc(3);
        chk({o_use_internal, o_internal_48k}, 2'b10);
        i_clock_sel = DAIM_SEL_EXT;
        cyc(10);
        chk(o_use_internal, 0);
        $display("done: clock select");
        repeat (10000) frame(f, 8, 2);
        $display("done: saturation");
        complete_run();
    end
endmodule // tb_daim_monitor
`default_nettype wire
